// ---- core/pll_regs_pkg.sv ----
// Package for the synthesizer control register bank and its packet forwarder.
// Assumes a single 100 MHz clock that also stands for the reference input.
package pll_regs_pkg;

   // ==========================================================
   // Register addresses
   localparam logic [4:0] ADDR_ID_PTR   = 5'h00;
   localparam logic [4:0] ADDR_RSV      = 5'h01;
   localparam logic [4:0] ADDR_REFERENCE_DIVIDER   = 5'h02;
   localparam logic [4:0] ADDR_INTG     = 5'h03;
   localparam logic [4:0] ADDR_FRAC     = 5'h04;
   localparam logic [4:0] ADDR_PACKET   = 5'h05;
   localparam logic [4:0] ADDR_LINKRATE = 5'h0a;

   // ==========================================================
   // Field positions and widths
   localparam int PTR_MSB      = 4;
   localparam int SOFT_RST_BIT = 5;
   localparam int RSV_W        = 10;
   localparam int REFERENCE_DIVIDER_W     = 14;
   localparam int INTG_W       = 19;
   localparam int FRAC_W       = 24;
   localparam int RATE_LSB     = 13;
   localparam int RATE_MSB     = 14;
   localparam int PKT_W        = 16;

   // ==========================================================
   // Reset values
   localparam logic [RSV_W-1:0]    RSV_RESET    = 10'h002;
   localparam logic [REFERENCE_DIVIDER_W-1:0] REFERENCE_DIVIDER_RESET = 14'h0001;
   localparam logic [INTG_W-1:0]   INTG_RESET   = 19'h00019;
   localparam logic [FRAC_W-1:0]   FRAC_RESET   = 24'h000000;
   localparam logic [1:0]          RATE_RESET   = 2'h1;
   localparam logic [2:0]          SUBSYS_ID_OSC = 3'h0;

   // ==========================================================
   // Timing
   localparam int CLK_MHZ       = 100;
   localparam int LINK_MAX_MHZ  = 50;
   // Least clock cycles per link clock period, rounded up.
   localparam int LINK_MIN_PERIOD = (CLK_MHZ + LINK_MAX_MHZ - 1) / LINK_MAX_MHZ;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [4:0]  addr;
      logic [23:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [8:0] payload;
      logic [3:0] reg_index;
      logic [2:0] target_id;
   } vco_pkt_t;

endpackage

// ---- core/pll_regs_vco_forwarder.sv ----
// Control register bank with indirect packet forwarder to the oscillator subsystem.
// Assumes the serial port front end presents one-cycle read and write strobes.
`timescale 1ns/100ps
`default_nettype none

module pll_regs_vco_forwarder
   import pll_regs_pkg::*;
#(
   parameter logic [23:0] PART_ID = 24'h5a3c1e, // Value is arbitrary.
   parameter int          DEPTH   = 2
) (
   // Clock, reset, enable
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic                ce_i,
   // Register port
   input  wire reg_req_t            req_i,
   output logic [23:0]              rdata_o,
   output logic                     rvalid_o,
   output logic                     pkt_ready_o,
   // Calibration controller
   input  wire logic                cal_write_i,
   input  wire logic [8:0]          cal_payload_i,
   // Configuration inputs and outputs
   input  wire logic                ref_buffer_on_i,
   output logic [REFERENCE_DIVIDER_W-1:0]      ref_div_o,
   output logic [INTG_W-1:0]        divide_integer_o,
   output logic [FRAC_W-1:0]        divide_fraction_o,
   output logic [4:0]               open_read_ptr_o,
   output logic                     soft_reset_o,
   // Internal link to the oscillator subsystem
   output logic                     internal_vco_serial_clk_o,
   output logic                     internal_vco_serial_data_o,
   output logic                     internal_vco_serial_sel_o
);

   // ==========================================================
   // Register decode
   wire logic wr_id      = req_i.wr && (req_i.addr == ADDR_ID_PTR);
   wire logic wr_rsv     = req_i.wr && (req_i.addr == ADDR_RSV);
   wire logic wr_reference_divider  = req_i.wr && (req_i.addr == ADDR_REFERENCE_DIVIDER);
   wire logic wr_intg    = req_i.wr && (req_i.addr == ADDR_INTG);
   wire logic wr_frac    = req_i.wr && (req_i.addr == ADDR_FRAC);
   wire logic wr_packet  = req_i.wr && (req_i.addr == ADDR_PACKET);
   wire logic wr_rate    = req_i.wr && (req_i.addr == ADDR_LINKRATE);

   logic [RSV_W-1:0]    rsv_q;
   logic [REFERENCE_DIVIDER_W-1:0] reference_divider_q;
   logic [INTG_W-1:0]   intg_q;
   logic [FRAC_W-1:0]   frac_q;
   logic [1:0]          rate_q;
   logic [4:0]          ptr_q;
   logic                srst_q;
   vco_pkt_t            host_pkt_q;
   vco_pkt_t            last_sent_q;
   logic [23:0]         rdata_q;
   logic                rvalid_q;

   // ==========================================================
   // Packet buffer
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);

   vco_pkt_t        mem_q [DEPTH];
   logic [PW-1:0]   wptr_q;
   logic [PW-1:0]   rptr_q;
   logic [PW:0]     count_q;

   wire logic       fifo_full  = (count_q == DEPTH_C);
   wire logic       fifo_empty = (count_q == '0);
   wire logic       push_req   = wr_packet || cal_write_i;
   wire logic       push       = push_req && !fifo_full;
   logic            pop;

   // Calibration only owns the payload; id and index stay as the host left them.
   wire vco_pkt_t cal_pkt = '{payload: cal_payload_i,
                             reg_index: host_pkt_q.reg_index,
                             target_id: host_pkt_q.target_id};
   // Host writes win over a calibration write in the same cycle.
   wire vco_pkt_t push_pkt = wr_packet ? vco_pkt_t'(req_i.wdata[PKT_W-1:0])
                                       : cal_pkt;

   function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
      next_ptr = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
   endfunction

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wptr_q  <= '0;
         rptr_q  <= '0;
         count_q <= '0;
      end else if (ce_i) begin
         if (push) begin
            wptr_q <= next_ptr(wptr_q);
         end
         if (pop) begin
            rptr_q <= next_ptr(rptr_q);
         end
         count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   always_ff @(posedge clk_i) begin
      if (ce_i && push) begin
         mem_q[wptr_q] <= push_pkt;
      end
   end

   assign pkt_ready_o = !fifo_full;

   // ==========================================================
   // Register file
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rsv_q      <= RSV_RESET;
         reference_divider_q   <= REFERENCE_DIVIDER_RESET;
         intg_q     <= INTG_RESET;
         frac_q     <= FRAC_RESET;
         rate_q     <= RATE_RESET;
         ptr_q      <= '0;
         srst_q     <= 1'b0;
         host_pkt_q <= '0;
      end else if (ce_i) begin
         if (wr_rsv) begin
            rsv_q <= req_i.wdata[RSV_W-1:0];
         end
         if (wr_reference_divider) begin
            reference_divider_q <= req_i.wdata[REFERENCE_DIVIDER_W-1:0];
         end
         if (wr_intg) begin
            intg_q <= req_i.wdata[INTG_W-1:0];
         end
         if (wr_frac) begin
            frac_q <= req_i.wdata[FRAC_W-1:0];
         end
         if (wr_rate) begin
            rate_q <= req_i.wdata[RATE_MSB:RATE_LSB];
         end
         if (wr_id) begin
            ptr_q <= req_i.wdata[PTR_MSB:0];
         end
         srst_q <= wr_id && req_i.wdata[SOFT_RST_BIT];
         if (wr_packet && push) begin
            host_pkt_q <= vco_pkt_t'(req_i.wdata[PKT_W-1:0]);
         end
      end
   end

   // The divider is bypassed with a ratio of one while the reference buffer is off.
   assign ref_div_o         = ref_buffer_on_i ? reference_divider_q : REFERENCE_DIVIDER_W'(1);
   assign divide_integer_o  = intg_q;
   assign divide_fraction_o = frac_q;
   assign open_read_ptr_o   = ptr_q;
   assign soft_reset_o      = srst_q;

   // ==========================================================
   // Read path
   logic [23:0] rmux;
   always_comb begin
      rmux = '0;
      case (req_i.addr)
         ADDR_ID_PTR:   rmux = PART_ID;
         ADDR_RSV:      rmux = {14'h0000, rsv_q};
         ADDR_REFERENCE_DIVIDER:   rmux = {10'h000, reference_divider_q};
         ADDR_INTG:     rmux = {5'h00, intg_q};
         ADDR_FRAC:     rmux = frac_q;
         ADDR_PACKET:   rmux = {8'h00, last_sent_q};
         ADDR_LINKRATE: rmux = {9'h000, rate_q, 13'h0000};
         default:       rmux = '0;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_q  <= '0;
         rvalid_q <= 1'b0;
      end else if (ce_i) begin
         rvalid_q <= req_i.rd;
         if (req_i.rd) begin
            rdata_q <= rmux;
         end
      end
   end

   assign rdata_o  = rdata_q;
   assign rvalid_o = rvalid_q;

   // ==========================================================
   // Link serializer
   // Half period is 2^rate cycles, so the full period is 2^(rate+1); rate 1 divides by four.
   typedef enum logic {LINK_IDLE, LINK_SHIFT} link_state_t;

   link_state_t      state_q;
   logic [3:0]       div_q;
   logic [3:0]       bit_q;
   logic [PKT_W-1:0] sh_q;
   logic             sclk_q;

   wire logic [3:0] half_m1 = 4'((4'h1 << rate_q) - 4'h1);
   wire logic       tick    = (div_q == half_m1);
   wire logic       idle    = (state_q == LINK_IDLE);
   wire logic       fall    = tick && sclk_q;

   // A new packet waits in the buffer until the link is idle.
   assign pop = idle && !fifo_empty;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q     <= LINK_IDLE;
         div_q       <= '0;
         bit_q       <= '0;
         sh_q        <= '0;
         sclk_q      <= 1'b0;
         last_sent_q <= '0;
      end else if (ce_i) begin
         case (state_q)
            LINK_IDLE: begin
               div_q  <= '0;
               sclk_q <= 1'b0;
               if (pop) begin
                  sh_q        <= mem_q[rptr_q];
                  last_sent_q <= mem_q[rptr_q];
                  bit_q       <= 4'hf;
                  state_q     <= LINK_SHIFT;
               end
            end
            LINK_SHIFT: begin
               div_q <= tick ? 4'h0 : 4'(div_q + 4'h1);
               if (tick) begin
                  sclk_q <= !sclk_q;
               end
               if (fall) begin
                  if (bit_q == 4'h0) begin
                     state_q <= LINK_IDLE;
                  end else begin
                     bit_q <= 4'(bit_q - 4'h1);
                     sh_q  <= {sh_q[PKT_W-2:0], 1'b0};
                  end
               end
            end
            default: state_q <= LINK_IDLE;
         endcase
      end
   end

   // The subsystem decodes id, index and payload; only id zero is acted on.
   assign internal_vco_serial_clk_o  = sclk_q;
   assign internal_vco_serial_data_o = sh_q[PKT_W-1];
   assign internal_vco_serial_sel_o  = !idle;

   // ==========================================================
   // Checks
   logic [4:0] rise_cnt_q;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rise_cnt_q <= '0;
      end else if (ce_i) begin
         if (idle) begin
            rise_cnt_q <= '0;
         end else if (tick && !sclk_q) begin
            rise_cnt_q <= 5'(rise_cnt_q + 5'h1);
         end
      end
   end

   // The link clock is timed from its own edges, so a wrong divider shows at the first fall.
   logic       clk_prev_q;
   logic [3:0] hold_q;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         clk_prev_q <= 1'b0;
         hold_q     <= '0;
      end else if (ce_i) begin
         clk_prev_q <= sclk_q;
         if (sclk_q != clk_prev_q) begin
            hold_q <= 4'h1;
         end else if (hold_q != 4'hf) begin
            hold_q <= 4'(hold_q + 4'h1);
         end
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i || !ce_i);

   sequence frame_start_s;
      idle ##1 !idle;
   endsequence
   sequence frame_end_s;
      !idle ##1 idle;
   endsequence
   sequence frame_busy_s;
      !idle ##1 !idle;
   endsequence
   sequence cal_into_empty_s;
      cal_write_i && !wr_packet && fifo_empty ##1 pop;
   endsequence

   sixteen_edges_a: assert property (frame_end_s |-> $past(rise_cnt_q) == 5'h10)
      else $error("Frame did not carry sixteen clock edges.");
   msb_first_a: assert property (frame_start_s |-> internal_vco_serial_data_o == last_sent_q[15])
      else $error("First bit is not the packet MSB.");
   link_rate_a: assert property (clk_prev_q && !internal_vco_serial_clk_o |->
      hold_q == 4'(4'h1 << rate_q))
      else $error("Link clock high phase has the wrong length.");
   cal_keeps_a: assert property (cal_into_empty_s |->
      mem_q[rptr_q][6:0] == $past(host_pkt_q[6:0]) && mem_q[rptr_q].payload == $past(cal_payload_i))
      else $error("Calibration altered id or index.");
   cal_field_a: assert property (cal_write_i && !wr_packet |-> cal_pkt[6:0] == host_pkt_q[6:0]
      && cal_pkt.payload == cal_payload_i)
      else $error("Calibration packet fields wrong.");
   id_read_a: assert property (req_i.rd && req_i.addr == ADDR_ID_PTR |=> rdata_o == PART_ID)
      else $error("Identity word read back wrong.");
   ptr_load_a: assert property (wr_id |=> open_read_ptr_o == $past(req_i.wdata[4:0]))
      else $error("Read pointer not loaded.");
   soft_rst_a: assert property (wr_id && req_i.wdata[SOFT_RST_BIT] |=> soft_reset_o)
      else $error("Soft reset strobe missing.");
   ref_div_a: assert property (!ref_buffer_on_i |-> ref_div_o == 14'h0001)
      else $error("Reference divider active with buffer off.");
   pkt_read_a: assert property (req_i.rd && req_i.addr == ADDR_PACKET
      |=> rdata_o[15:0] == $past(last_sent_q))
      else $error("Packet readback is not the last sent packet.");
   hold_off_a: assert property (frame_busy_s |->
      $stable(last_sent_q) && $stable(rptr_q))
      else $error("Packet taken while link busy.");
   rsv_read_a: assert property (req_i.rd && req_i.addr == ADDR_RSV |=> rdata_o[23:10] == '0)
      else $error("Reserved register upper bits not zero.");

endmodule

`default_nettype wire

// ---- dv/vco_link_model.sv ----
// Far-side receiver model of the internal oscillator link.
// Assumes the link clock idles low and data is steady at its rising edge.
`timescale 1ns/100ps
`default_nettype none
module vco_link_model (
   // Clock
   input  wire logic        clk_i,
   // Internal link
   input  wire logic        internal_vco_serial_clk_i,
   input  wire logic        internal_vco_serial_data_i,
   input  wire logic        internal_vco_serial_sel_i,
   // Observation
   output logic [15:0]      pkt_o,
   output int               nbits_o,
   output int               period_o
);
   // ==========================================
   // Receiver
   logic [8:0] regs [16];
   int         cyc  = 0;
   int         last = 0;
   initial begin
      pkt_o    = '0;
      nbits_o  = 0;
      period_o = 0;
   end
   always @(negedge clk_i) cyc <= cyc + 1;
   always @(posedge internal_vco_serial_sel_i) nbits_o = 0;
   always @(posedge internal_vco_serial_clk_i) begin
      if (internal_vco_serial_sel_i) begin
         pkt_o    = {pkt_o[14:0], internal_vco_serial_data_i};
         nbits_o  = nbits_o + 1;
         period_o = cyc - last;
         last     = cyc;
         // Only id zero answers, so other ids leave the registers alone.
         if (nbits_o == 16 && pkt_o[2:0] == 3'h0) regs[pkt_o[6:3]] = pkt_o[15:7];
      end
   end
endmodule
`default_nettype wire

// ---- dv/tb_pll_regs_vco_forwarder.sv ----
// Self-checking bench of the register bank and its packet forwarder.
// Assumes one 100 MHz clock and the far-side link model beside it.
`timescale 1ns/100ps
`default_nettype none
module tb_pll_regs_vco_forwarder;
   import pll_regs_pkg::*;
   // ==========================================
   // Signals
   localparam logic [23:0] ID = 24'h3c5a96; // Value is arbitrary.
   logic clk_i = 0, rst_i = 1, ce_i = 1, cal_write_i = 0, ref_buffer_on_i = 0;
   logic [8:0]  cal_payload_i = '0;
   reg_req_t    req_i = '0;
   logic [23:0] rdata_o, fr_o;
   logic [13:0] rd_o;
   logic [18:0] in_o;
   logic [4:0]  ptr_o;
   logic [15:0] rx_pkt;
   logic        rvalid_o, rdy_o, srst_o, vclk, vdat, vsel;
   int          nbits, period, n_rx = 0, n_mismatch = 0, checks = 0, cyc = 0;
   logic [31:0] xs = 99;
   logic [15:0] exp_q [$];
   always #5 clk_i = ~clk_i;
   pll_regs_vco_forwarder #(.PART_ID(ID)) i_pll_regs_vco_forwarder (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .req_i(req_i), .rdata_o(rdata_o),
      .rvalid_o(rvalid_o), .pkt_ready_o(rdy_o), .cal_write_i(cal_write_i),
      .cal_payload_i(cal_payload_i), .ref_buffer_on_i(ref_buffer_on_i), .ref_div_o(rd_o),
      .divide_integer_o(in_o), .divide_fraction_o(fr_o), .open_read_ptr_o(ptr_o),
      .soft_reset_o(srst_o), .internal_vco_serial_clk_o(vclk), .internal_vco_serial_data_o(vdat), .internal_vco_serial_sel_o(vsel));
   vco_link_model i_vco_link_model (
      .clk_i(clk_i), .internal_vco_serial_clk_i(vclk), .internal_vco_serial_data_i(vdat), .internal_vco_serial_sel_i(vsel),
      .pkt_o(rx_pkt), .nbits_o(nbits), .period_o(period));
   // ==========================================
   // Tasks
   function logic [31:0] rnd();
      xs = xs ^ (xs << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
      return xs;
   endfunction
   task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic nop();
      req_i = '0;
      @(posedge clk_i);
      #1;
   endtask
   task automatic wr(input logic [4:0] a, input logic [23:0] d, input bit keep = 0);
      req_i = '{1'b1, 1'b0, a, d};
      @(posedge clk_i);
      #1;
      if (!keep) nop();
   endtask
   task automatic rd(input logic [4:0] a, input logic [23:0] e);
      req_i = '{1'b0, 1'b1, a, 24'h0};
      @(posedge clk_i);
      #1;
      check("rvalid", 24'(rvalid_o), 24'h1);
      check("rdata", rdata_o, e);
      nop();
   endtask
   task automatic wait_rx(input int n);
      for (int i = 0; i < 3000 && n_rx < n; i++) @(posedge clk_i);
      #1;
      check("frames", 24'(n_rx), 24'(n));
   endtask
   task automatic stop_test();
      if (n_mismatch == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ==========================================
   // Frame comparison against the expected queue
   always @(negedge vsel) begin
      if (!rst_i) begin
         n_rx++;
         check("bits", 24'(nbits), 24'h10);
         check("packet", 24'(rx_pkt), 24'(exp_q.pop_front()));
         check("payload", 24'(i_vco_link_model.regs[rx_pkt[6:3]]), 24'(rx_pkt[15:7]));
      end
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         stop_test();
      end
   end
   // ==========================================
   // Main sequence
   logic [4:0]  ra [7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h0a, 5'h1f};
   logic [23:0] rv [7] = '{ID, 24'h2, 24'h1, 24'h19, 24'h0, 24'h2000, 24'h0};
   logic [23:0] mk [7] = '{0, 24'h3ff, 24'h3fff, 24'h7ffff, 24'hffffff, 24'h6000, 0};
   logic [23:0] d;
   logic [15:0] p, last;
   initial begin
      repeat (12) @(posedge clk_i);
      #1;
      rst_i = 0;
      check("reference_divider", 24'(rd_o), 24'h1);
      for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
      for (int i = 1; i < 6; i++) begin
         d = rnd() & mk[i];
         if (i == 2) d = rnd() % 16383 + 1;
         if (i == 3) d = rnd() % 524265 + 20;
         wr(ra[i], d);
         rv[i] = d;
         rd(ra[i], d);
      end
      check("integer", 24'(in_o), rv[3]);
      check("fraction", fr_o, rv[4]);
      check("reference_divider_off", 24'(rd_o), 24'h1);
      ref_buffer_on_i = 1;
      #1;
      check("reference_divider_on", 24'(rd_o), rv[2]);
      wr(5'h00, 24'h00001b, 1);
      check("ptr", 24'(ptr_o), 24'h1b);
      check("srst_idle", 24'(srst_o), 24'h0);
      wr(5'h00, 24'h00002a, 1);
      check("srst", 24'(srst_o), 24'h1);
      nop();
      check("srst_end", 24'(srst_o), 24'h0);
      rd(5'h00, ID);
      rd(5'h03, rv[3]);
      for (int r = 0; r < 4; r++) begin
         wr(5'h0a, 24'(r) << 13);
         d = 24'(rnd());
         p = {d[12:0], SUBSYS_ID_OSC};
         if (r == 0) p = {d[7:0], 1'b0, 4'h0, SUBSYS_ID_OSC};
         exp_q.push_back(p);
         wr(5'h05, 24'(p));
         wait_rx(r + 1);
         check("period", 24'(period), 24'(2 << r));
         check("link_idle", 24'(vclk), 24'h0);
         rd(5'h05, 24'(p));
      end
      wr(5'h0a, 24'h0);
      for (int k = 0; k < 4; k++) begin
         d = 24'(rnd());
         p = {d[8:0], 4'(k + 3), SUBSYS_ID_OSC};
         if (k == 3) check("full", 24'(rdy_o), 24'h0);
         if (k < 3) exp_q.push_back(p);
         if (k == 2) last = p;
         wr(5'h05, 24'(p), 1);
      end
      nop();
      wait_rx(7);
      d = 24'(rnd());
      last = {d[8:0], 4'h0, SUBSYS_ID_OSC};
      exp_q.push_back(last);
      wr(5'h05, 24'(last));
      wait_rx(8);
      d = 24'(rnd()) & 24'h0001ff;
      cal_payload_i = d[8:0];
      cal_write_i = 1;
      exp_q.push_back({d[8:0], last[6:0]});
      @(posedge clk_i);
      #1;
      cal_write_i = 0;
      wait_rx(9);
      rd(5'h05, 24'({d[8:0], last[6:0]}));
      rv[3] = 24'(rnd() % 524265 + 20);
      rv[4] = 24'(rnd());
      wr(5'h03, rv[3]);
      wr(5'h04, rv[4]);
      check("retune_int", 24'(in_o), rv[3]);
      check("retune_frac", fr_o, rv[4]);
      stop_test();
   end
endmodule
`default_nettype wire
